// ===== logic/ssc_pkg.sv
// shared constants and carrier types for the sixteen switch serial control block
package ssc_pkg;

  // ***************************************************************
  // sizes and field positions
  // ***************************************************************
  localparam int unsigned WORD_W        = 24;
  localparam int unsigned N_OUT         = 16;
  localparam int unsigned ANY_FAULT_BIT = 23;
  localparam int unsigned OV_FLAG_BIT   = 22;
  localparam int unsigned CMD_MSB       = 23;
  localparam int unsigned CMD_LSB       = 18;
  localparam int unsigned GSR_OV_BIT    = 16;
  localparam logic [5:0]  ZERO_PAD      = 6'h00;

  // ***************************************************************
  // command selector codes
  // ***************************************************************
  localparam logic [5:0] CMD_ONOFF   = 6'h00;
  localparam logic [5:0] CMD_OL_EN   = 6'h01;
  localparam logic [5:0] CMD_GSR     = 6'h02;
  localparam logic [5:0] CMD_PWM_SEL = 6'h04;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [N_OUT-1:0]  RST_OUTS  = 16'h0000;
  localparam logic [WORD_W-1:0] RST_WORD  = 24'h000000;
  localparam logic              RST_RETRY = 1'b0;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned OV_FILT_US     = 50;
  localparam int unsigned FAULT_MIN_US   = 100;
  localparam int unsigned FAULT_MAX_US   = 450;
  localparam int unsigned OV_FILT_CYC    = OV_FILT_US * CLK_MHZ;
  localparam int unsigned FAULT_FILT_CYC = FAULT_MIN_US * CLK_MHZ;
  localparam int unsigned FAULT_MAX_CYC  = FAULT_MAX_US * CLK_MHZ;
  localparam int unsigned CNT_W          = 17;

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic si;
  } ssc_spi_in_s;

  typedef struct packed {
    logic [N_OUT-1:0] short_on;
    logic [N_OUT-1:0] open_off;
  } ssc_diag_in_s;

endpackage : ssc_pkg

// ===== logic/ssc_spi_control.sv
// serial control, fault reporting and output gating of the sixteen low side switches
`timescale 1ns/1ps

// Behaviour
// - serial output driven only while selected
// - chip select rise latches and executes command
// - chip select fall loads fault word
// - clock and data ignored while deselected
// - serial input sampled on clock falling edge
// - next fault bit shifted out on rise
// - twenty four bits fill the command register
// - word: any fault, over voltage, zeros, outputs
// - one means faulted, zero means normal
// - both words most significant bit first
// - low logic supply holds reset, outputs off
// - reset input clears all, outputs off
// - filtered over voltage forces all outputs off
// - recovery restores or clears per retry bit
// - over voltage shutdown reports two flags
// - faults must persist before bit sets
// - new output state applied within limit
// - pwm input gates any selected outputs
// - bits 23..18 select command, 15..0 outputs
// - on/off command: one on, zero off
module ssc_spi_control #(
  parameter int unsigned OV_FILT_CYC    = ssc_pkg::OV_FILT_CYC,
  parameter int unsigned FAULT_FILT_CYC = ssc_pkg::FAULT_FILT_CYC
) (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_ce,
  input  wire logic                       i_logic_supply_ok,
  input  wire logic                       i_battery_ov,
  input  wire logic                       i_pwm,
  input  wire ssc_pkg::ssc_spi_in_s       i_spi,
  input  wire ssc_pkg::ssc_diag_in_s      i_diag,
  output logic                            o_so,
  output logic                            o_so_oe,
  output logic [ssc_pkg::N_OUT-1:0]       o_low_side_switches,
  output logic [ssc_pkg::N_OUT-1:0]       o_ol_cur_en
);

  localparam logic [ssc_pkg::CNT_W-1:0] OV_LIM  = ssc_pkg::CNT_W'(OV_FILT_CYC);
  localparam logic [ssc_pkg::CNT_W-1:0] FLT_LIM = ssc_pkg::CNT_W'(FAULT_FILT_CYC);
  localparam logic [ssc_pkg::CNT_W-1:0] CNT_ONE = 17'h00001;
  localparam logic [ssc_pkg::CNT_W-1:0] CNT_ZERO = 17'h00000;

  // ***************************************************************
  // reset and edge detection
  // ***************************************************************
  logic rst;
  logic cs_q_r;
  logic sclk_q_r;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  assign rst = ~i_rst_n | ~i_logic_supply_ok;

  // pins are synchronous to the core clock, so one stage of history finds the edges
  assign cs_fall   = cs_q_r & ~i_spi.cs_n;
  assign cs_rise   = ~cs_q_r & i_spi.cs_n;
  // clock edges count only while selected now and before; relies on a low clock at select
  // edges, so an edge coinciding with a select edge is dropped
  assign sclk_rise = ~sclk_q_r & i_spi.sclk & ~i_spi.cs_n & ~cs_q_r;
  assign sclk_fall = sclk_q_r & ~i_spi.sclk & ~i_spi.cs_n & ~cs_q_r;

  // ***************************************************************
  // state
  // ***************************************************************
  logic [ssc_pkg::WORD_W-1:0] sh_r;
  logic [ssc_pkg::WORD_W-1:0] sh_nxt;
  logic                       so_r;
  logic                       so_nxt;
  logic                       so_oe_r;
  logic                       so_oe_nxt;
  logic [ssc_pkg::N_OUT-1:0]  on_cmd_r;
  logic [ssc_pkg::N_OUT-1:0]  on_cmd_nxt;
  logic [ssc_pkg::N_OUT-1:0]  ol_en_r;
  logic [ssc_pkg::N_OUT-1:0]  ol_en_nxt;
  logic [ssc_pkg::N_OUT-1:0]  pwm_sel_r;
  logic [ssc_pkg::N_OUT-1:0]  pwm_sel_nxt;
  logic                       ov_retry_r;
  logic                       ov_retry_nxt;
  logic [ssc_pkg::CNT_W-1:0]  ov_cnt_r;
  logic [ssc_pkg::CNT_W-1:0]  ov_cnt_nxt;
  logic                       ov_shut_r;
  logic                       ov_shut_nxt;
  logic                       ov_flag_r;
  logic                       ov_flag_nxt;
  logic [ssc_pkg::N_OUT-1:0]  sw_r;
  logic [ssc_pkg::N_OUT-1:0]  sw_nxt;
  logic [ssc_pkg::N_OUT-1:0]  flt_r;
  logic [ssc_pkg::N_OUT-1:0]  flt_nxt;
  logic [ssc_pkg::WORD_W-1:0] status_word;
  logic [5:0]                 cmd_sel;

  assign status_word = {(ov_flag_r | (|flt_r)), ov_flag_r, ssc_pkg::ZERO_PAD, flt_r};
  assign cmd_sel     = sh_r[ssc_pkg::CMD_MSB:ssc_pkg::CMD_LSB];

  // ***************************************************************
  // serial shift register
  // ***************************************************************
  // one register serves both directions: data in at the bottom, data out at the top,
  // so beyond 24 clocks the received bits stream on to the next device in a chain
  always_comb begin
    sh_nxt    = sh_r;
    so_nxt    = so_r;
    so_oe_nxt = ~i_spi.cs_n;
    if (cs_fall) begin
      sh_nxt = status_word;
      so_nxt = 1'b0;
    end else begin
      if (sclk_rise) begin
        so_nxt = sh_r[ssc_pkg::WORD_W-1];
      end
      if (sclk_fall) begin
        sh_nxt = {sh_r[ssc_pkg::WORD_W-2:0], i_spi.si};
      end
    end
  end

  // ***************************************************************
  // command decode and over voltage
  // ***************************************************************
  always_comb begin
    on_cmd_nxt   = on_cmd_r;
    ol_en_nxt    = ol_en_r;
    pwm_sel_nxt  = pwm_sel_r;
    ov_retry_nxt = ov_retry_r;
    ov_cnt_nxt   = CNT_ZERO;
    ov_shut_nxt  = ov_shut_r;
    ov_flag_nxt  = ov_flag_r;
    if (cs_rise) begin
      unique case (cmd_sel)
        ssc_pkg::CMD_ONOFF:   on_cmd_nxt   = sh_r[ssc_pkg::N_OUT-1:0];
        ssc_pkg::CMD_OL_EN:   ol_en_nxt    = sh_r[ssc_pkg::N_OUT-1:0];
        ssc_pkg::CMD_GSR:     ov_retry_nxt = sh_r[ssc_pkg::GSR_OV_BIT];
        ssc_pkg::CMD_PWM_SEL: pwm_sel_nxt  = sh_r[ssc_pkg::N_OUT-1:0];
        default:              on_cmd_nxt   = on_cmd_r;
      endcase
    end
    if (i_battery_ov) begin
      ov_cnt_nxt = (ov_cnt_r < OV_LIM) ? ov_cnt_r + CNT_ONE : ov_cnt_r;
      if (ov_cnt_r >= OV_LIM - CNT_ONE) begin
        ov_shut_nxt = 1'b1;
      end
    end else if (ov_shut_r) begin
      ov_shut_nxt = 1'b0;
      if (!ov_retry_r) begin
        on_cmd_nxt = ssc_pkg::RST_OUTS;
      end
    end
    // the flag is cleared once it has been captured for reporting; a shutdown still
    // standing sets it again and wins over that clear
    if (cs_fall) begin
      ov_flag_nxt = 1'b0;
    end
    if (ov_shut_r || ov_shut_nxt) begin
      ov_flag_nxt = 1'b1;
    end
  end

  // ***************************************************************
  // output gating
  // ***************************************************************
  always_comb begin
    // registered once, so a command reaches the switches two cycles after select rises
    sw_nxt = on_cmd_r & (~pwm_sel_r | {ssc_pkg::N_OUT{i_pwm}});
    if (ov_shut_r) begin
      sw_nxt = ssc_pkg::RST_OUTS;
    end
  end

  // ***************************************************************
  // fault persistence filters
  // ***************************************************************
  // the filter length sits at the low end of the window; the master must still wait
  // out the long end before trusting a read
  for (genvar g = 0; g < ssc_pkg::N_OUT; g++) begin : g_flt
    logic [ssc_pkg::CNT_W-1:0] cnt_r;
    logic [ssc_pkg::CNT_W-1:0] cnt_nxt;
    logic                      raw;

    assign raw = sw_r[g] ? i_diag.short_on[g] : i_diag.open_off[g];

    always_comb begin
      cnt_nxt    = CNT_ZERO;
      flt_nxt[g] = 1'b0;
      if (raw) begin
        cnt_nxt    = (cnt_r < FLT_LIM) ? cnt_r + CNT_ONE : cnt_r;
        flt_nxt[g] = (cnt_r >= FLT_LIM - CNT_ONE);
      end
    end

    always_ff @(posedge i_core_clk) begin
      if (rst) begin
        cnt_r    <= CNT_ZERO;
        flt_r[g] <= 1'b0;
      end else if (i_ce) begin
        cnt_r    <= cnt_nxt;
        flt_r[g] <= flt_nxt[g];
      end
    end
  end

  // ***************************************************************
  // registers: edge history
  // ***************************************************************
  // history resets to an idle bus, so a select already low at reset release
  // still shows up as a fresh falling edge
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      cs_q_r   <= 1'b1;
      sclk_q_r <= 1'b0;
    end else if (i_ce) begin
      cs_q_r   <= i_spi.cs_n;
      sclk_q_r <= i_spi.sclk;
    end
  end

  // ***************************************************************
  // registers: serial shift
  // ***************************************************************
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      sh_r    <= ssc_pkg::RST_WORD;
      so_r    <= 1'b0;
      so_oe_r <= 1'b0;
    end else if (i_ce) begin
      sh_r    <= sh_nxt;
      so_r    <= so_nxt;
      so_oe_r <= so_oe_nxt;
    end
  end

  // ***************************************************************
  // registers: command and over voltage
  // ***************************************************************
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      on_cmd_r   <= ssc_pkg::RST_OUTS;
      ol_en_r    <= ssc_pkg::RST_OUTS;
      pwm_sel_r  <= ssc_pkg::RST_OUTS;
      ov_retry_r <= ssc_pkg::RST_RETRY;
      ov_cnt_r   <= CNT_ZERO;
      ov_shut_r  <= 1'b0;
      ov_flag_r  <= 1'b0;
    end else if (i_ce) begin
      on_cmd_r   <= on_cmd_nxt;
      ol_en_r    <= ol_en_nxt;
      pwm_sel_r  <= pwm_sel_nxt;
      ov_retry_r <= ov_retry_nxt;
      ov_cnt_r   <= ov_cnt_nxt;
      ov_shut_r  <= ov_shut_nxt;
      ov_flag_r  <= ov_flag_nxt;
    end
  end

  // ***************************************************************
  // registers: output gating
  // ***************************************************************
  // a stalled core holds the switches where they are rather than dropping them
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      sw_r <= ssc_pkg::RST_OUTS;
    end else if (i_ce) begin
      sw_r <= sw_nxt;
    end
  end

  assign o_so                = so_r;
  assign o_so_oe             = so_oe_r;
  assign o_low_side_switches = sw_r;
  assign o_ol_cur_en         = ol_en_r;

endmodule : ssc_spi_control

// ===== tb/ssc_spi_control_properties.sv
// port level assertions for the serial control block
`timescale 1ns/1ps
module ssc_spi_control_properties #(
  parameter int unsigned OV_FILT_CYC    = 8,
  parameter int unsigned FAULT_FILT_CYC = 16
) (
  input logic                 i_core_clk,
  input logic                 i_rst_n,
  input logic                 i_ce,
  input logic                 i_logic_supply_ok,
  input logic                 i_battery_ov,
  input logic                 i_pwm,
  input ssc_pkg::ssc_spi_in_s i_spi,
  input logic                 o_so,
  input logic                 o_so_oe,
  input logic [15:0]          o_low_side_switches,
  input logic [15:0]          o_ol_cur_en
);
  // ****
  // checks
  // ****
  wire rst_a = !i_rst_n || !i_logic_supply_ok;
  // consecutive over voltage samples taken while the core runs
  logic [31:0] ov_run;
  always_ff @(posedge i_core_clk) begin
    if (rst_a || !i_ce || !i_battery_ov) begin
      ov_run <= 32'h00000000;
    end else begin
      ov_run <= ov_run + 32'h00000001;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  a_oe_follows_cs: assert property (disable iff (rst_a)
    $past(i_ce) |-> o_so_oe == !$past(i_spi.cs_n))
    else $error("so enable does not follow select");
  a_so_clear_sel: assert property (disable iff (rst_a)
    $fell(i_spi.cs_n) && i_ce && $past(i_ce) |=> !o_so)
    else $error("so not cleared at select");
  a_so_on_rise: assert property (disable iff (rst_a) $changed(o_so) |->
    ($past(i_spi.sclk) && !$past(i_spi.sclk, 2) && !$past(i_spi.cs_n))
    || ($past(i_spi.cs_n, 2) && !$past(i_spi.cs_n)))
    else $error("so moved without clock rise");
  a_ol_after_cs: assert property (disable iff (rst_a)
    $changed(o_ol_cur_en) |-> $past(i_spi.cs_n) && !$past(i_spi.cs_n, 2))
    else $error("load current enable moved off select rise");
  a_sw_after_cs: assert property (disable iff (rst_a)
    $changed(o_low_side_switches) && $past(i_pwm) == $past(i_pwm, 2) && !i_battery_ov
    && !$past(i_battery_ov) && !$past(i_battery_ov, 2) && !$past(i_battery_ov, 3)
    |-> $past(i_spi.cs_n, 2) && !$past(i_spi.cs_n, 3))
    else $error("switches moved off select rise");
  a_ov_all_off: assert property (disable iff (rst_a)
    ov_run > OV_FILT_CYC |-> o_low_side_switches == 16'h0000)
    else $error("switches on during over voltage");
  a_reset_clears: assert property (!i_rst_n |=>
    o_low_side_switches == 16'h0000 && o_ol_cur_en == 16'h0000 && !o_so_oe)
    else $error("reset left state");
  a_supply_off: assert property (!i_logic_supply_ok |=>
    o_low_side_switches == 16'h0000 && !o_so_oe && !o_so)
    else $error("low supply left switches on");
endmodule : ssc_spi_control_properties

bind ssc_spi_control ssc_spi_control_properties #(
  .OV_FILT_CYC(OV_FILT_CYC), .FAULT_FILT_CYC(FAULT_FILT_CYC)) i_props (
  .i_core_clk, .i_rst_n, .i_ce, .i_logic_supply_ok, .i_battery_ov, .i_pwm, .i_spi,
  .o_so, .o_so_oe, .o_low_side_switches, .o_ol_cur_en);

// ===== tb/ssc_spi_master.sv
// serial master model driving select, clock and data
`timescale 1ns/1ps
module ssc_spi_master (
  input  logic                 i_core_clk,
  input  logic                 i_so,
  output ssc_pkg::ssc_spi_in_s o_spi
);
  // ****
  // transfers
  // ****
  initial o_spi = 3'b100; // clock idles low while deselected
  task automatic stp(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : stp
  // three core cycles per level so the edge detector sees every level
  task automatic xfer(input logic [47:0] d, input int n, output logic [47:0] r);
    r = '0;
    o_spi.cs_n = 1'b0; // clock low at select fall
    stp(3);
    for (int i = n - 1; i >= 0; i--) begin // msb first, 24 bits a device
      o_spi.si   = d[i];
      o_spi.sclk = 1'b1;
      stp(3);
      r[i]       = i_so;
      o_spi.sclk = 1'b0; // data held across the fall
      stp(3);
    end
    o_spi.cs_n = 1'b1; // clock low at select rise
    o_spi.si   = ~o_spi.si;
    stp(4);
  endtask : xfer
endmodule : ssc_spi_master

// ===== tb/ssc_spi_control_tb.sv
// self-checking bench for the serial control block
`timescale 1ns/1ps
module ssc_spi_control_tb;
  // ****
  // harness
  // ****
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  sup_ok = 1'b1;
  logic                  ov = 1'b0;
  logic                  pwm = 1'b0;
  logic                  ce = 1'b1;
  ssc_pkg::ssc_diag_in_s diag = '0;
  ssc_pkg::ssc_spi_in_s  spi;
  logic                  so;
  logic                  so_oe;
  logic [15:0]           sw;
  logic [15:0]           ol;
  logic [47:0]           rsp;
  int                    n_mismatch = 0;
  int                    samples_checked = 0;
  wire                   so_w = so_oe ? so : 1'bz;
  always #2 clk = ~clk;
  ssc_spi_control #(.OV_FILT_CYC(8), .FAULT_FILT_CYC(16)) i_ssc_spi_control (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_logic_supply_ok(sup_ok),
    .i_battery_ov(ov), .i_pwm(pwm), .i_spi(spi), .i_diag(diag), .o_so(so),
    .o_so_oe(so_oe), .o_low_side_switches(sw), .o_ol_cur_en(ol));
  ssc_spi_master i_ssc_spi_master (.i_core_clk(clk), .i_so(so_w), .o_spi(spi));
  // ****
  // scenarios
  // ****
  task automatic stp(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : stp
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [5:0] sel, input logic [17:0] val);
    i_ssc_spi_master.xfer({24'h000000, sel, val}, 24, rsp);
  endtask : cmd
  task automatic t_onoff;
    cmd(ssc_pkg::CMD_ONOFF, 18'h0A5C3);
    chk(rsp, 48'h0);
    chk(sw, 16'hA5C3);
    chk(so_oe, 1'b0);
    cmd(6'h3F, 18'h00000);
    chk(sw, 16'hA5C3);
    cmd(ssc_pkg::CMD_OL_EN, 18'h01234);
    chk(ol, 16'h1234);
  endtask : t_onoff
  task automatic t_fault;
    diag = '{short_on: 16'h8005, open_off: 16'h0005};
    stp(4);
    cmd(ssc_pkg::CMD_ONOFF, 18'h0A5C3);
    chk(rsp, 48'h0);
    stp(20); // reads spaced beyond the fault filter
    cmd(ssc_pkg::CMD_ONOFF, 18'h0A5C3);
    chk(rsp, 48'h808005);
    diag = '0;
    stp(4);
    i_ssc_spi_master.xfer(48'h00F0F0_0000FF, 48, rsp);
    chk(rsp, 48'h000000_00F0F0);
    chk(sw, 16'h00FF);
  endtask : t_fault
  task automatic t_pwm;
    cmd(ssc_pkg::CMD_PWM_SEL, 18'h0000F);
    chk(sw, 16'h00F0);
    pwm = 1'b1;
    stp(3);
    chk(sw, 16'h00FF);
  endtask : t_pwm
  task automatic t_ce;
    ce = 1'b0;
    stp(2);
    cmd(ssc_pkg::CMD_ONOFF, 18'h0F0F0);
    chk(sw, 16'h00FF);
    ce = 1'b1;
    stp(3);
    chk(sw, 16'h00FF);
  endtask : t_ce
  task automatic t_ov(input logic retry, input logic [15:0] exp);
    cmd(ssc_pkg::CMD_GSR, {1'b0, retry, 16'h0000});
    cmd(ssc_pkg::CMD_ONOFF, 18'h000FF);
    ov = 1'b1;
    stp(12);
    chk(sw, 16'h0000);
    ov = 1'b0;
    stp(4);
    chk(sw, exp);
    cmd(6'h3F, 18'h00000);
    chk(rsp, 48'hC00000);
  endtask : t_ov
  task automatic t_rst;
    cmd(ssc_pkg::CMD_OL_EN, 18'h0F00F);
    chk(ol, 16'hF00F);
    rst_n = 1'b0;
    stp(3);
    rst_n = 1'b1;
    chk({ol, sw}, 32'h0);
    cmd(ssc_pkg::CMD_ONOFF, 18'h08001);
    chk(sw, 16'h8001);
    sup_ok = 1'b0;
    stp(3);
    sup_ok = 1'b1;
    chk(sw, 16'h0000);
  endtask : t_rst
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    stp(12);
    rst_n = 1'b1;
    stp(2);
    t_onoff;
    t_fault;
    t_pwm;
    t_ce;
    t_ov(1'b0, 16'h0000);
    t_ov(1'b1, 16'h00FF);
    t_rst;
    tally_and_finish;
  end
  initial begin
    #40000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule : ssc_spi_control_tb
